// ===== include/tccr_pkg.sv
package tccr_pkg;
   // local bus window and register locations
   localparam logic [23:0] LOCAL_BUS_WINDOW_BASE = 24'h400000;
   localparam logic [23:0] SPEED_COUNTER_CONFIG_ADDR =
      LOCAL_BUS_WINDOW_BASE | 24'h000002;
   localparam logic [23:0] ACQ_CONTROL_ADDR =
      LOCAL_BUS_WINDOW_BASE | 24'h000020;
   localparam logic [23:0] SPEED_RESULT_ADDR =
      LOCAL_BUS_WINDOW_BASE | 24'h000024;
   localparam logic [23:0] NV_SETTINGS_BASE = 24'h100000;
   localparam logic [23:0] CHANNEL_SETTINGS_OFFSET = 24'h00000F;
   localparam logic [23:0] CHANNEL_SETTINGS_ADDR =
      NV_SETTINGS_BASE + CHANNEL_SETTINGS_OFFSET;

   // speed counter config fields
   localparam int CFG_EDGE_BIT = 7;
   localparam int CFG_ZERO_BIT = 5;
   localparam int CFG_STALE_BIT = 4;
   localparam logic [7:0] CFG_WRITE_MASK = 8'hB0;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // channel settings byte: coupling low nibble, source disable high
   localparam int SET_COUPLING_LSB = 0;
   localparam int SET_SOURCE_LSB = 4;
   localparam int NUM_CHANNELS = 4;
   localparam logic [7:0] SETTINGS_RESET = 8'hFF;

   // acquisition control fields and speed result stale bit
   localparam int CTL_START_BIT = 0;
   localparam int CTL_STOP_BIT = 1;
   localparam int CTL_MASTER_BIT = 2;
   localparam int CTL_ACQ_BIT = 3;
   localparam int RES_STALE_BIT = 31;

   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int BLINK_HALF_MS = 125;
   localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
   localparam int SCLK_HALF_CYC = 2;
   localparam int TRIG_PULSE_LINK_CYC = 4;
   localparam int SYNC_PERIOD_LINK_CYC = 8;
   localparam int PERIOD_W = 24;
endpackage

// ===== include/tccr_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tccr_sync_if #(parameter int W = 1);
   logic [W-1:0] async_in;
   logic [W-1:0] sync_out;
   modport src (output async_in, input sync_out);
   modport dst (input async_in, output sync_out);
endinterface
`default_nettype wire

// ===== src/tccr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tccr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   tccr_sync_if.dst bus
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } tccr_sync_st_t;

   tccr_sync_st_t st_q;
   tccr_sync_st_t st_d;

   // first stage feeds only the second stage
   always_comb begin
      st_d = st_q;
      st_d.meta = bus.async_in;
      st_d.stab = st_q.meta;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= {RST_VAL, RST_VAL};
      end else begin
         st_q <= st_d;
      end
   end

   assign bus.sync_out = st_q.stab;
endmodule
`default_nettype wire

// ===== src/tccr_regs.sv
// Functional notes
// - config register at window base plus 0x2
// - bit 7 selects falling period start edge
// - bit 5 reads zeros between measurements
// - bit 4 enables stale-data indication
// - config defaults zero, reset on host exit
// - settings bits 0-3 coupling, 1 is DC
// - settings bits 4-7 disable 4 mA source
// - modules share differential sample clock
// - trigger line is active low
// - sync strobe active low, aligns sampling
// - green when idle, blinking amber acquiring
`timescale 1ns/1ps
`default_nettype none
module tccr_regs
   import tccr_pkg::*;
#(
   parameter int BLINK_HALF = BLINK_HALF_CYC,
   parameter int TRIG_PULSE = TRIG_PULSE_LINK_CYC,
   parameter int SYNC_PERIOD = SYNC_PERIOD_LINK_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_host_exit,
   input wire logic i_lb_cs,
   input wire logic i_lb_we,
   input wire logic [23:0] i_lb_addr,
   input wire logic [31:0] i_lb_wdata,
   output logic [31:0] o_lb_rdata,
   output logic o_lb_ack,
   input wire logic i_tach,
   output logic o_tach_falling,
   output logic [3:0] o_dc_coupling,
   output logic [3:0] o_source_off,
   output logic o_sclk_p,
   output logic o_sclk_n,
   output logic o_sclk_oe,
   input wire logic i_link_clk,
   input wire logic i_trig_n,
   output logic o_trig_n,
   output logic o_trig_oe,
   input wire logic i_sync_n,
   output logic o_sync_n,
   output logic o_sync_oe,
   output logic o_sample_strobe,
   output logic o_led_green,
   output logic o_led_amber
);
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] nvs;
      logic master;
      logic acq;
      logic tach_prev;
      logic armed;
      logic [PERIOD_W-1:0] per_cnt;
      logic [PERIOD_W-1:0] result;
      logic fresh;
      logic trig_tgl_prev;
      logic sync_tgl_prev;
      logic sample_strobe;
      logic [31:0] blink_cnt;
      logic amber;
      logic [7:0] sclk_cnt;
      logic sclk;
      logic sclk_n;
      logic green;
      logic [31:0] rdata;
      logic ack;
   } tccr_sys_st_t;

   typedef struct packed {
      logic acq_prev;
      logic [7:0] trig_cnt;
      logic [7:0] sync_cnt;
      logic trig_drive;
      logic sync_drive;
      logic trig_in_prev;
      logic sync_in_prev;
      logic trig_tgl;
      logic sync_tgl;
   } tccr_link_st_t;

   tccr_sys_st_t s_q;
   tccr_sys_st_t s_d;
   tccr_link_st_t l_q;
   tccr_link_st_t l_d;

   // synchronisers: sys side sees tach pin and link toggles,
   // link side sees the wire levels and the sys acquisition and master levels
   tccr_sync_if #(.W(3)) sys_sync ();
   tccr_sync_if #(.W(4)) link_sync ();

   assign sys_sync.async_in = {i_tach, l_q.trig_tgl, l_q.sync_tgl};
   assign link_sync.async_in = {i_trig_n, i_sync_n, s_q.acq, s_q.master};

   tccr_sync #(.W(3), .RST_VAL(3'h0)) u_sys_sync (
      .i_clk(i_clk_sys),
      .i_rst_n(i_rst_n),
      .bus(sys_sync)
   );

   tccr_sync #(.W(4), .RST_VAL(4'hC)) u_link_sync (
      .i_clk(i_link_clk),
      .i_rst_n(i_rst_n),
      .bus(link_sync)
   );

   logic tach_s;
   logic trig_tgl_s;
   logic sync_tgl_s;
   logic trig_in_s;
   logic sync_in_s;
   logic acq_s;
   logic master_s;

   assign {tach_s, trig_tgl_s, sync_tgl_s} = sys_sync.sync_out;
   assign {trig_in_s, sync_in_s, acq_s, master_s} = link_sync.sync_out;

   // ---------------- system clock domain ----------------
   logic wr;
   logic rd;
   logic tach_edge;
   logic [PERIOD_W-1:0] shown;
   logic stale;

   always_comb begin
      s_d = s_q;
      wr = i_lb_cs && i_lb_we;
      rd = i_lb_cs && !i_lb_we;
      stale = !s_q.fresh;
      shown = (s_q.cfg[CFG_ZERO_BIT] && stale) ? '0 : s_q.result;

      // register writes
      s_d.ack = i_lb_cs;
      if (wr && i_lb_addr == SPEED_COUNTER_CONFIG_ADDR) begin
         s_d.cfg = i_lb_wdata[7:0] & CFG_WRITE_MASK;
      end
      if (wr && i_lb_addr == CHANNEL_SETTINGS_ADDR) begin
         // only the low byte of the word is stored
         s_d.nvs = i_lb_wdata[7:0];
      end
      if (wr && i_lb_addr == ACQ_CONTROL_ADDR) begin
         s_d.master = i_lb_wdata[CTL_MASTER_BIT];
         if (i_lb_wdata[CTL_START_BIT]) begin
            s_d.acq = 1'b1;
         end else if (i_lb_wdata[CTL_STOP_BIT]) begin
            s_d.acq = 1'b0;
         end
      end
      if (i_host_exit) begin
         s_d.cfg = CFG_RESET;
      end

      // register reads, unmapped answers zero
      s_d.rdata = '0;
      if (rd) begin
         unique case (i_lb_addr)
            SPEED_COUNTER_CONFIG_ADDR: begin
               s_d.rdata[7:0] = s_q.cfg;
            end
            CHANNEL_SETTINGS_ADDR: begin
               s_d.rdata[7:0] = s_q.nvs;
            end
            ACQ_CONTROL_ADDR: begin
               s_d.rdata[CTL_MASTER_BIT] = s_q.master;
               s_d.rdata[CTL_ACQ_BIT] = s_q.acq;
            end
            SPEED_RESULT_ADDR: begin
               s_d.rdata[PERIOD_W-1:0] = shown;
               s_d.rdata[RES_STALE_BIT] = s_q.cfg[CFG_STALE_BIT] && stale;
               s_d.fresh = 1'b0;
            end
            default: begin
               s_d.rdata = '0;
            end
         endcase
      end

      // period measurement on speed counter zero
      s_d.tach_prev = tach_s;
      tach_edge = s_q.cfg[CFG_EDGE_BIT] ? (s_q.tach_prev && !tach_s)
                                        : (!s_q.tach_prev && tach_s);
      if (tach_edge) begin
         if (s_q.armed) begin
            s_d.result = s_q.per_cnt;
            s_d.fresh = 1'b1; // a new result beats a same-cycle read
         end
         s_d.armed = 1'b1;
         s_d.per_cnt = PERIOD_W'(1);
      end else if (s_q.per_cnt != '1) begin
         s_d.per_cnt = s_q.per_cnt + PERIOD_W'(1);
      end

      // slave starts on a trigger from the linked module
      s_d.trig_tgl_prev = trig_tgl_s;
      if (trig_tgl_s != s_q.trig_tgl_prev && !s_q.master) begin
         s_d.acq = 1'b1;
      end
      s_d.sync_tgl_prev = sync_tgl_s;
      // gated by the next acq level so a strobe never outlives a stop
      s_d.sample_strobe = (sync_tgl_s != s_q.sync_tgl_prev) && s_d.acq;

      // master drives the shared sample clock
      if (s_q.sclk_cnt == 8'(SCLK_HALF_CYC - 1)) begin
         s_d.sclk_cnt = '0;
         s_d.sclk = !s_q.sclk;
      end else begin
         s_d.sclk_cnt = s_q.sclk_cnt + 8'h01;
      end
      s_d.sclk_n = !s_d.sclk;

      // status indicator
      if (!s_q.acq) begin
         s_d.blink_cnt = '0;
         s_d.amber = 1'b0;
      end else if (s_q.blink_cnt == 32'(BLINK_HALF - 1)) begin
         s_d.blink_cnt = '0;
         s_d.amber = !s_q.amber;
      end else begin
         s_d.blink_cnt = s_q.blink_cnt + 32'h1;
      end
      s_d.green = !s_d.acq;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
         s_q.cfg <= CFG_RESET;
         s_q.nvs <= SETTINGS_RESET;
         s_q.sclk_n <= 1'b1;
         s_q.green <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------- link clock domain ----------------
   always_comb begin
      l_d = l_q;
      l_d.acq_prev = acq_s;
      // master pulls trigger low for a fixed burst at acquisition start
      if (acq_s && !l_q.acq_prev && master_s) begin
         l_d.trig_cnt = 8'(TRIG_PULSE);
      end else if (l_q.trig_cnt != '0) begin
         l_d.trig_cnt = l_q.trig_cnt - 8'h01;
      end
      l_d.trig_drive = (l_d.trig_cnt != '0);
      // master pulls sync low one link cycle per sample period
      if (!(acq_s && master_s)) begin
         l_d.sync_cnt = '0;
         l_d.sync_drive = 1'b0;
      end else if (l_q.sync_cnt == 8'(SYNC_PERIOD - 1)) begin
         l_d.sync_cnt = '0;
         l_d.sync_drive = 1'b1;
      end else begin
         l_d.sync_cnt = l_q.sync_cnt + 8'h01;
         l_d.sync_drive = 1'b0;
      end
      // falling edges on the wires become toggles for the sys domain
      l_d.trig_in_prev = trig_in_s;
      l_d.sync_in_prev = sync_in_s;
      if (l_q.trig_in_prev && !trig_in_s) begin
         l_d.trig_tgl = !l_q.trig_tgl;
      end
      if (l_q.sync_in_prev && !sync_in_s) begin
         l_d.sync_tgl = !l_q.sync_tgl;
      end
   end

   // the link clock may stop; a pulse in flight just ends late
   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         l_q <= '0;
         l_q.trig_in_prev <= 1'b1;
         l_q.sync_in_prev <= 1'b1;
      end else begin
         l_q <= l_d;
      end
   end

   // outputs: each taken straight from a flop, except o_trig_n and o_sync_n, which are tied low
   assign o_lb_rdata = s_q.rdata;
   assign o_lb_ack = s_q.ack;
   assign o_tach_falling = s_q.cfg[CFG_EDGE_BIT];
   assign o_dc_coupling = s_q.nvs[SET_COUPLING_LSB +: NUM_CHANNELS];
   assign o_source_off = s_q.nvs[SET_SOURCE_LSB +: NUM_CHANNELS];
   assign o_sclk_p = s_q.sclk;
   assign o_sclk_n = s_q.sclk_n;
   assign o_sclk_oe = s_q.master;
   // open-drain style: low level only, enable marks the pull
   assign o_trig_n = 1'b0;
   assign o_trig_oe = l_q.trig_drive;
   assign o_sync_n = 1'b0;
   assign o_sync_oe = l_q.sync_drive;
   assign o_sample_strobe = s_q.sample_strobe;
   assign o_led_green = s_q.green;
   assign o_led_amber = s_q.amber;
endmodule
`default_nettype wire

// ===== test/tccr_link_peer.sv
`timescale 1ns/1ps
`default_nettype none
module tccr_link_peer (
   input wire logic i_link_clk,
   input wire logic i_rst_n,
   input wire logic i_trig_go,
   input wire logic i_sync_go,
   output logic o_trig_oe,
   output logic o_sync_oe
);
   logic [2:0] n_q;
   // second module, clocked by the link clock
   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         n_q <= 3'h0;
         o_trig_oe <= 1'b0;
         o_sync_oe <= 1'b0;
      end else begin
         n_q <= n_q + 3'h1;
         o_trig_oe <= i_trig_go;
         o_sync_oe <= i_sync_go && n_q == 3'h0;
      end
   end
endmodule
`default_nettype wire

// ===== test/tccr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tccr_regs_chk import tccr_pkg::*; (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_link_clk,
   input wire logic i_host_exit,
   input wire logic i_lb_cs,
   input wire logic i_lb_we,
   input wire logic [23:0] i_lb_addr,
   input wire logic [31:0] i_lb_wdata,
   input wire logic [31:0] o_lb_rdata,
   input wire logic o_lb_ack,
   input wire logic o_tach_falling,
   input wire logic [3:0] o_dc_coupling,
   input wire logic [3:0] o_source_off,
   input wire logic o_sclk_p,
   input wire logic o_sclk_n,
   input wire logic o_sclk_oe,
   input wire logic o_trig_n,
   input wire logic o_trig_oe,
   input wire logic o_sample_strobe,
   input wire logic o_led_green,
   input wire logic o_led_amber
);
   logic cw, sw;
   assign cw = i_lb_cs && i_lb_we && i_lb_addr == SPEED_COUNTER_CONFIG_ADDR;
   assign sw = i_lb_cs && i_lb_we && i_lb_addr == CHANNEL_SETTINGS_ADDR;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   a_ack_follows: assert property (i_lb_cs |=> o_lb_ack)
      else $error("no ack after request");
   a_ack_cause: assert property (o_lb_ack |-> $past(i_lb_cs))
      else $error("ack without request");
   a_rdata_idle: assert property (!o_lb_ack |-> o_lb_rdata == 32'h0)
      else $error("read data outside ack");
   a_cfg_zero_bits: assert property (o_lb_ack &&
      $past(i_lb_addr) == SPEED_COUNTER_CONFIG_ADDR
      |-> (o_lb_rdata & 32'hFFFFFF4F) == 32'h0)
      else $error("config unused bits set");
   a_edge_copy: assert property (cw && !i_host_exit ##1 !i_lb_cs
      && !i_host_exit |=> o_tach_falling == $past(i_lb_wdata[7], 2))
      else $error("edge select wrong");
   a_exit_clear: assert property (i_host_exit && !i_lb_cs
      ##1 !i_lb_cs |=> !o_tach_falling)
      else $error("exit did not clear config");
   a_set_copy: assert property (sw ##1 !i_lb_cs |=>
      {o_source_off, o_dc_coupling} == $past(i_lb_wdata[7:0], 2))
      else $error("settings outputs wrong");
   a_green_idle: assert property (o_led_green ##1 o_led_green
      |-> !o_led_amber)
      else $error("amber while idle");
   a_trig_master: assert property (@(posedge i_link_clk)
      o_trig_oe |-> o_sclk_oe && !o_trig_n)
      else $error("trigger drive wrong");
   a_sclk_diff: assert property (o_sclk_p != o_sclk_n)
      else $error("sample clock not complementary");
   a_sclk_rate: assert property ($rose(o_sclk_p) |=> o_sclk_p ##1 !o_sclk_p)
      else $error("sample clock rate wrong");
   a_strobe_pulse: assert property (o_sample_strobe |->
      !o_led_green ##1 !o_sample_strobe)
      else $error("strobe wrong");
endmodule
bind tccr_regs tccr_regs_chk chk_u (.*);
`default_nettype wire

// ===== test/tccr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tccr_regs_tb_top import tccr_pkg::*;;
   typedef struct {
      logic w;
      logic [23:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } tccr_row_t;
   localparam logic [23:0] CF = SPEED_COUNTER_CONFIG_ADDR;
   localparam logic [23:0] ST = CHANNEL_SETTINGS_ADDR;
   localparam logic [23:0] UM = LOCAL_BUS_WINDOW_BASE | 24'h000004;
   localparam logic [23:0] CT = ACQ_CONTROL_ADDR;
   localparam logic [23:0] SR = SPEED_RESULT_ADDR;
   tccr_row_t rows [9] = '{
      '{1'b0, CF, 32'h0, 32'h0},
      '{1'b0, ST, 32'h0, 32'hFF},
      '{1'b1, CF, 32'hFFFFFFFF, 32'h0},
      '{1'b0, CF, 32'h0, 32'hB0},
      '{1'b1, ST, 32'h5A, 32'h0},
      '{1'b0, ST, 32'h0, 32'h5A},
      '{1'b1, UM, 32'hFFFFFFFF, 32'h0},
      '{1'b0, UM, 32'h0, 32'h0},
      '{1'b0, 24'h000002, 32'h0, 32'h0}};
   logic i_clk_sys, i_rst_n, i_host_exit, i_lb_cs, i_lb_we, i_tach;
   logic i_link_clk, i_trig_n, i_sync_n, o_lb_ack, o_tach_falling;
   logic [23:0] i_lb_addr;
   logic [31:0] i_lb_wdata, o_lb_rdata, r;
   logic [3:0] o_dc_coupling, o_source_off;
   logic o_sclk_p, o_sclk_n, o_sclk_oe, o_trig_n, o_trig_oe, o_sync_n;
   logic o_sync_oe, o_sample_strobe, o_led_green, o_led_amber, b;
   logic p_trig_oe, p_sync_oe, trig_go, sync_go, tach_en;
   int bad_count = 0, total_checks = 0, n, k, tc = 0;
   // idle-high wires: either module may pull low
   assign i_trig_n = (o_trig_oe ? o_trig_n : 1'b1) & !p_trig_oe;
   assign i_sync_n = (o_sync_oe ? o_sync_n : 1'b1) & !p_sync_oe;
   tccr_regs #(.BLINK_HALF(8)) dut_u (.*);
   tccr_link_peer peer_u (.i_link_clk(i_link_clk), .i_rst_n(i_rst_n),
      .i_trig_go(trig_go), .i_sync_go(sync_go),
      .o_trig_oe(p_trig_oe), .o_sync_oe(p_sync_oe));
   initial begin
      i_clk_sys = 0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      i_link_clk = 0;
      #7;
      forever #62.5 i_link_clk = ~i_link_clk;
   end
   // speed input with a 20-cycle period
   always @(posedge i_clk_sys) begin
      if (tach_en) begin
         tc <= (tc == 9) ? 0 : tc + 1;
         if (tc == 9) i_tach <= ~i_tach;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task lim(input int c, input int m);
      if (c >= m) begin
         bad_count++;
         results();
      end
   endtask
   // ack is registered, so look one step after the edge
   task automatic acc(input logic w, input logic [23:0] a,
         input logic [31:0] d);
      @(posedge i_clk_sys);
      i_lb_cs <= 1;
      i_lb_we <= w;
      i_lb_addr <= a;
      i_lb_wdata <= d;
      @(posedge i_clk_sys);
      i_lb_cs <= 0;
      #1;
      for (n = 0; n < 8 && o_lb_ack !== 1'b1; n++) @(posedge i_clk_sys) #1;
      lim(n, 8);
      r = o_lb_rdata;
   endtask
   initial begin
      {i_host_exit, i_lb_cs, i_lb_we, i_tach} = 4'h0;
      {tach_en, trig_go, sync_go} = 3'h0;
      i_lb_addr = 24'h0;
      i_lb_wdata = 32'h0;
      i_rst_n = 0;
      repeat (10) @(posedge i_clk_sys);
      i_rst_n <= 1;
      #1;
      chk({o_source_off, o_dc_coupling, o_tach_falling, o_led_green},
         32'h3FD);
      foreach (rows[i]) begin
         acc(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(r, rows[i].e);
      end
      chk({o_source_off, o_dc_coupling, o_tach_falling}, 32'hB5);
      @(posedge i_clk_sys) i_host_exit <= 1;
      @(posedge i_clk_sys) i_host_exit <= 0;
      acc(0, CF, 0);
      chk(r, 0);
      $display("register table done");
      acc(1, CF, 32'h30);
      tach_en <= 1;
      repeat (100) @(posedge i_clk_sys);
      tach_en <= 0;
      repeat (10) @(posedge i_clk_sys);
      acc(0, SR, 0);
      chk(r & 32'hFFFFFF, 32'h14);
      acc(0, SR, 0);
      chk(r & 32'hFFFFFF, 32'h0);
      acc(1, CF, 32'h10);
      acc(0, SR, 0);
      chk(r, 32'h80000014);
      acc(1, CF, 32'h0);
      acc(0, SR, 0);
      chk(r, 32'h14);
      acc(1, CF, 32'h90);
      @(posedge i_clk_sys) i_tach <= 1;
      repeat (10) @(posedge i_clk_sys);
      acc(0, SR, 0);
      chk(r, 32'h80000014);
      @(posedge i_clk_sys) i_tach <= 0;
      repeat (10) @(posedge i_clk_sys);
      acc(0, SR, 0);
      chk(r[31], 1'b0);
      $display("speed counter done");
      acc(1, CT, 32'h5);
      for (n = 0; n < 200 && o_trig_oe !== 1'b1; n++)
         @(posedge i_clk_sys) #1;
      lim(n, 200);
      chk({o_sclk_oe, o_led_green}, 32'h2);
      @(posedge i_clk_sys) #1;
      k = 0;
      repeat (32) begin
         b = o_led_amber;
         @(posedge i_clk_sys) #1;
         k += (o_led_amber !== b);
      end
      chk(k, 4);
      for (n = 0; n < 200 && o_sync_oe !== 1'b1; n++) @(posedge i_clk_sys);
      lim(n, 200);
      k = 0;
      repeat (100) begin
         @(posedge i_clk_sys) #1;
         k += (o_sample_strobe === 1'b1);
      end
      chk(k, 4);
      acc(1, CT, 32'h2);
      for (n = 0; n < 200 && o_led_green !== 1'b1; n++) @(posedge i_clk_sys);
      lim(n, 200);
      @(posedge i_clk_sys) #1;
      chk(o_led_amber, 0);
      $display("master link done");
      @(posedge i_clk_sys) trig_go <= 1;
      repeat (4) @(posedge i_link_clk);
      @(posedge i_clk_sys) trig_go <= 0;
      for (n = 0; n < 200 && o_led_green !== 1'b0; n++) @(posedge i_clk_sys);
      lim(n, 200);
      acc(0, CT, 0);
      chk(r & 32'hC, 32'h8);
      @(posedge i_clk_sys) sync_go <= 1;
      k = 0;
      repeat (200) begin
         @(posedge i_clk_sys) #1;
         k += (o_sample_strobe === 1'b1);
      end
      @(posedge i_clk_sys) sync_go <= 0;
      chk(k > 5 && k < 10, 1);
      acc(1, CT, 32'h2);
      $display("slave link done");
      @(posedge i_clk_sys) i_rst_n <= 0;
      repeat (10) @(posedge i_clk_sys);
      i_rst_n <= 1;
      acc(0, CF, 0);
      chk({r[7:0], o_source_off, o_dc_coupling}, 32'hFF);
      $display("second reset done");
      results();
   end
endmodule
`default_nettype wire
